// file: logic/cpft_fault_timer.sv
// Fault timing and gate control of a single-cell protector, with AXI4-Lite status access
`timescale 1ns/1ps

// How it works
// - Overvoltage held for its delay drops charge gate
// - Undervoltage held for its delay drops discharge gate
// - Discharge overcurrent held for delay drops discharge gate
// - Load short drops discharge gate after fixed delay
// - Charge overcurrent held for delay drops charge gate
// - Timer starts on fault; trips if still present
// - Recovery timer restores gate if fault stays away
// - Thresholds and delays fixed; never writable
// - Zero-volt charging only with charger above minimum
// - Depleted cell: charge gate high at start level
// - Cell below inhibit level: charge gate only through zero-volt path
// - Gate high means FET on, low off
// - Normal mode keeps both gates on
// - Undervoltage state disables charge overcurrent detection
module cpft_fault_timer #(
	parameter int unsigned TICK_CYCLES     = cpft_pkg::TICK_CYCLES,
	parameter int unsigned OVP_DLY_TICKS   = cpft_pkg::OVP_OPT_US[cpft_pkg::OVP_SEL] / cpft_pkg::TICK_US,
	parameter int unsigned UVP_DLY_TICKS   = cpft_pkg::UVP_OPT_US[cpft_pkg::UVP_SEL] / cpft_pkg::TICK_US,
	parameter int unsigned OCD_DLY_TICKS   = cpft_pkg::OCD_OPT_US[cpft_pkg::OCD_SEL] / cpft_pkg::TICK_US,
	parameter int unsigned OCC_DLY_TICKS   = cpft_pkg::OCC_OPT_US[cpft_pkg::OCC_SEL] / cpft_pkg::TICK_US,
	parameter int unsigned SHT_DLY_TICKS   = cpft_pkg::SHT_DLY_US / cpft_pkg::TICK_US,
	parameter int unsigned REC_DLY_TICKS   = cpft_pkg::REC_DLY_US / cpft_pkg::TICK_US,
	parameter bit          ZERO_VOLT_CHG   = 1'b1
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       cell_overvoltage_fault,
	input  wire logic                       cell_undervoltage_fault,
	input  wire logic                       discharge_overcurrent_fault,
	input  wire logic                       charge_overcurrent_fault,
	input  wire logic                       load_short_fault,
	input  wire logic                       charger_above_min,
	input  wire logic                       zero_volt_charge_start_level,
	input  wire logic                       zero_volt_charge_inhibit_level,
	input  wire cpft_pkg::cpft_axil_req_t   axil_req,
	output cpft_pkg::cpft_axil_rsp_t        axil_rsp,
	output logic                            charge_gate_out,
	output logic                            discharge_gate_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 8;
	localparam int NF   = cpft_pkg::NUM_FAULTS;

	logic [NPIN-1:0] pin_meta_r;
	logic [NPIN-1:0] pin_sync_r;
	logic [NF-1:0]   flt_s;
	logic            chgr_ok_s;
	logic            zv_start_s;
	logic            depleted_s;

	// Comparator outputs are asynchronous to clk, so two stages first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {zero_volt_charge_inhibit_level, zero_volt_charge_start_level, charger_above_min,
				load_short_fault, charge_overcurrent_fault, discharge_overcurrent_fault,
				cell_undervoltage_fault, cell_overvoltage_fault};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign flt_s      = pin_sync_r[NF-1:0];
	assign chgr_ok_s  = pin_sync_r[5];
	assign zv_start_s = pin_sync_r[6];
	assign depleted_s = pin_sync_r[7];

	// ----------------------------------------------------------------
	// Oscillator tick divider
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_r;
	logic        tick;

	assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

	// One enable pulse per tick period; all delays count these pulses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt_r <= 16'h0000;
		end else if (tick) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Fault delay and recovery timers
	// ----------------------------------------------------------------
	localparam int CW = cpft_pkg::CNT_W;
	// Limits are elaboration constants: nothing at run time can alter them
	localparam logic [CW-1:0] TRIP_LIM [NF] = '{CW'(OVP_DLY_TICKS), CW'(UVP_DLY_TICKS),
		CW'(OCD_DLY_TICKS), CW'(OCC_DLY_TICKS), CW'(SHT_DLY_TICKS)};
	localparam logic [CW-1:0] REC_LIM = CW'(REC_DLY_TICKS);

	logic [NF-1:0] trip_r;
	logic [NF-1:0] flt_eff;
	logic [CW-1:0] cnt_r [NF];

	// Charge overcurrent sensing is blind while the cell is over-discharged
	always_comb begin
		flt_eff                  = flt_s;
		flt_eff[cpft_pkg::F_OCC] = flt_s[cpft_pkg::F_OCC] & ~trip_r[cpft_pkg::F_UVP];
	end

	for (genvar i = 0; i < NF; i++) begin : g_chan
		logic          run;
		logic [CW-1:0] lim;

		// Counting toward a trip while idle, toward release while tripped
		assign run = trip_r[i] ? ~flt_eff[i] : flt_eff[i];
		assign lim = trip_r[i] ? REC_LIM : TRIP_LIM[i];

		// A broken run restarts the count, so only a steady condition acts
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				trip_r[i] <= 1'b0;
				cnt_r[i]  <= '0;
			end else if (!run) begin
				cnt_r[i] <= '0;
			end else if (tick) begin
				if (cnt_r[i] == lim - CW'(1)) begin
					trip_r[i] <= ~trip_r[i];
					cnt_r[i]  <= '0;
				end else begin
					cnt_r[i] <= cnt_r[i] + CW'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Gate drive
	// ----------------------------------------------------------------
	logic [1:0] control_r;
	logic       chg_nxt;
	logic       dsg_nxt;

	// Gate high turns the FET on; a tripped fault on its side turns it off, charge overcurrent not while undervoltage is tripped
	always_comb begin
		dsg_nxt = ~(trip_r[cpft_pkg::F_UVP] | trip_r[cpft_pkg::F_OCD] | trip_r[cpft_pkg::F_SHT])
			& ~control_r[cpft_pkg::CTL_FORCE_DSG];
		if (depleted_s) begin
			// Depleted cell: charge only through the zero-volt path
			chg_nxt = ZERO_VOLT_CHG & chgr_ok_s & zv_start_s
				& ~control_r[cpft_pkg::CTL_FORCE_CHG];
		end else begin
			chg_nxt = ~(trip_r[cpft_pkg::F_OVP]
				| (trip_r[cpft_pkg::F_OCC] & ~trip_r[cpft_pkg::F_UVP]))
				& ~control_r[cpft_pkg::CTL_FORCE_CHG];
		end
	end

	// Gates come up on after reset, as in normal mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			charge_gate_out    <= 1'b1;
			discharge_gate_out <= 1'b1;
		end else begin
			charge_gate_out    <= chg_nxt;
			discharge_gate_out <= dsg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] status_word;
	logic [31:0] config_word;

	// Address and data are taken together; simpler than two holding slots
	assign wr_go = axil_req.awvalid & axil_req.wvalid & ~bvalid_r;
	assign rd_go = axil_req.arvalid & ~rvalid_r;

	assign axil_rsp.awready = wr_go;
	assign axil_rsp.wready  = wr_go;
	assign axil_rsp.bvalid  = bvalid_r;
	assign axil_rsp.bresp   = bresp_r;
	assign axil_rsp.arready = rd_go;
	assign axil_rsp.rvalid  = rvalid_r;
	assign axil_rsp.rdata   = rdata_r;
	assign axil_rsp.rresp   = rresp_r;

	assign status_word = {20'h00000, discharge_gate_out, charge_gate_out, flt_s, trip_r};
	// Delay selections are visible but read-only
	assign config_word = {8'h00, 2'(cpft_pkg::OCC_SEL), 2'(cpft_pkg::OCD_SEL),
		2'(cpft_pkg::UVP_SEL), 2'(cpft_pkg::OVP_SEL), 15'h0000, ZERO_VOLT_CHG};

	// Control register; only byte lane 0 carries bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_r <= cpft_pkg::CONTROL_RESET;
		end else if (wr_go && axil_req.awaddr == cpft_pkg::REG_CONTROL && axil_req.wstrb[0]) begin
			control_r <= axil_req.wdata[1:0];
		end
	end

	// Write response one cycle after the take
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= cpft_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (axil_req.awaddr == cpft_pkg::REG_STATUS || axil_req.awaddr == cpft_pkg::REG_CONTROL
				|| axil_req.awaddr == cpft_pkg::REG_CONFIG) ? cpft_pkg::RESP_OKAY : cpft_pkg::RESP_DECERR;
		end else if (axil_req.bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read data one cycle after the take
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= cpft_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r  <= cpft_pkg::RESP_OKAY;
			unique case (axil_req.araddr)
				cpft_pkg::REG_STATUS:  rdata_r <= status_word;
				cpft_pkg::REG_CONTROL: rdata_r <= {30'h00000000, control_r};
				cpft_pkg::REG_CONFIG:  rdata_r <= config_word;
				default: begin
					rdata_r <= 32'h00000000;
					rresp_r <= cpft_pkg::RESP_DECERR;
				end
			endcase
		end else if (axil_req.rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic normal_mode;
	assign normal_mode = ~|trip_r & ~|control_r & ~depleted_s;

	chk_ovp_drops_chg: assert property ($rose(trip_r[cpft_pkg::F_OVP]) && !depleted_s
		|=> !charge_gate_out) else $error("overvoltage trip left charge gate on");
	chk_uvp_drops_dsg: assert property ($rose(trip_r[cpft_pkg::F_UVP])
		|=> !discharge_gate_out) else $error("undervoltage trip left discharge gate on");
	chk_ocd_drops_dsg: assert property ($rose(trip_r[cpft_pkg::F_OCD])
		|=> !discharge_gate_out) else $error("discharge overcurrent left gate on");
	chk_short_delay: assert property ($rose(trip_r[cpft_pkg::F_SHT])
		|-> $past(cnt_r[cpft_pkg::F_SHT]) == TRIP_LIM[cpft_pkg::F_SHT] - CW'(1) && $past(tick)
		##1 !discharge_gate_out) else $error("short trip at wrong count");
	chk_occ_drops_chg: assert property ($rose(trip_r[cpft_pkg::F_OCC]) && !depleted_s
		&& !trip_r[cpft_pkg::F_UVP] |=> !charge_gate_out) else $error("charge overcurrent left gate on");
	chk_trip_needs_fault: assert property ($rose(trip_r[cpft_pkg::F_OCD])
		|-> $past(flt_eff[cpft_pkg::F_OCD], 1)) else $error("trip without fault present");
	chk_recovery_clean: assert property ($fell(trip_r[cpft_pkg::F_OVP])
		|-> $past(!flt_eff[cpft_pkg::F_OVP]) && $past(cnt_r[cpft_pkg::F_OVP]) == REC_LIM - CW'(1))
		else $error("gate restored before recovery time");
	chk_config_fixed: assert property ($stable(config_word))
		else $error("configuration word changed");
	chk_zero_volt_gate: assert property (depleted_s && !chgr_ok_s |=> !charge_gate_out)
		else $error("depleted cell charged without charger");
	chk_zero_volt_start: assert property (depleted_s && chgr_ok_s && zv_start_s && !control_r[0]
		|=> charge_gate_out == ZERO_VOLT_CHG) else $error("zero volt start missed");
	chk_normal_both_on: assert property (normal_mode [*2]
		|-> charge_gate_out && discharge_gate_out) else $error("gate off in normal mode");
	chk_uvp_masks_occ: assert property (trip_r[cpft_pkg::F_UVP] && !trip_r[cpft_pkg::F_OCC]
		|=> !trip_r[cpft_pkg::F_OCC]) else $error("charge overcurrent tripped while over-discharged");
	chk_count_restart: assert property (!flt_eff[cpft_pkg::F_UVP] && !trip_r[cpft_pkg::F_UVP]
		|=> cnt_r[cpft_pkg::F_UVP] == '0) else $error("delay counter kept stale count");

	// ----------------------------------------------------------------
	// Per-channel timer checks
	// ----------------------------------------------------------------
	// A trip or a release off its terminal count would mean a glitch acted
	for (genvar k = 0; k < NF; k++) begin : g_chk
		chk_trip_at_limit: assert property ($rose(trip_r[k])
			|-> $past(tick) && $past(cnt_r[k]) == TRIP_LIM[k] - CW'(1) && $past(flt_eff[k]))
			else $error("fault timer tripped off its count");
		chk_release_at_limit: assert property ($fell(trip_r[k])
			|-> $past(tick) && $past(cnt_r[k]) == REC_LIM - CW'(1) && $past(!flt_eff[k]))
			else $error("recovery timer released off its count");
	end

	// ----------------------------------------------------------------
	// Gate hold checks
	// ----------------------------------------------------------------
	// Force bits may only ever take a gate off, never hold one on
	chk_force_chg_off: assert property (control_r[cpft_pkg::CTL_FORCE_CHG] |=> !charge_gate_out)
		else $error("forced charge gate still on");
	chk_force_dsg_off: assert property (control_r[cpft_pkg::CTL_FORCE_DSG] |=> !discharge_gate_out)
		else $error("forced discharge gate still on");
	// A tripped overvoltage keeps charging off for as long as it stays tripped
	chk_ovp_holds_chg: assert property (trip_r[cpft_pkg::F_OVP] && !depleted_s |=> !charge_gate_out)
		else $error("charge gate on while overvoltage tripped");
	// Charge overcurrent holds the gate off unless over-discharge masks it
	chk_occ_holds_chg: assert property (trip_r[cpft_pkg::F_OCC] && !trip_r[cpft_pkg::F_UVP] && !depleted_s
		|=> !charge_gate_out) else $error("charge gate on while overcurrent tripped");
	// Any tripped discharge-side fault keeps the discharge FET off
	chk_dsg_faults_off: assert property (trip_r[cpft_pkg::F_UVP] || trip_r[cpft_pkg::F_OCD]
		|| trip_r[cpft_pkg::F_SHT] |=> !discharge_gate_out) else $error("discharge gate on while tripped");
	// With nothing tripped on its side the discharge gate must come back
	chk_dsg_restore: assert property (!trip_r[cpft_pkg::F_UVP] && !trip_r[cpft_pkg::F_OCD]
		&& !trip_r[cpft_pkg::F_SHT] && !control_r[cpft_pkg::CTL_FORCE_DSG] |=> discharge_gate_out)
		else $error("discharge gate left off after recovery");
	// Below start level a depleted cell is never charged
	chk_zero_volt_wait: assert property (depleted_s && !zv_start_s |=> !charge_gate_out)
		else $error("depleted cell charged below start level");

	// ----------------------------------------------------------------
	// Bus answer checks
	// ----------------------------------------------------------------
	// Every take is answered on the very next edge
	chk_write_answer: assert property (wr_go |=> bvalid_r)
		else $error("write taken without response");
	chk_read_answer: assert property (rd_go |=> rvalid_r)
		else $error("read taken without response");
	// An address outside the map answers with a decode error
	chk_write_decerr: assert property (wr_go && axil_req.awaddr != cpft_pkg::REG_STATUS
		&& axil_req.awaddr != cpft_pkg::REG_CONTROL && axil_req.awaddr != cpft_pkg::REG_CONFIG
		|=> bresp_r == cpft_pkg::RESP_DECERR) else $error("unmapped write not refused");

	cov_occ_masked: cover property (trip_r[cpft_pkg::F_UVP] && flt_s[cpft_pkg::F_OCC]);
	cov_short_trip: cover property ($rose(trip_r[cpft_pkg::F_SHT]) ##1 !discharge_gate_out);
	cov_ovp_recover: cover property ($fell(trip_r[cpft_pkg::F_OVP]) ##1 charge_gate_out);
	cov_zero_volt: cover property (depleted_s && charge_gate_out);
	cov_axil_read: cover property (rd_go ##1 rvalid_r);

endmodule

// file: logic/cpft_pkg.sv
// Package for the cell protection fault timer: constants, option tables and bus carriers
package cpft_pkg;

	// ----------------------------------------------------------------
	// Fault channel indices
	// ----------------------------------------------------------------
	localparam int NUM_FAULTS = 5;
	localparam int F_OVP      = 0;	// Cell overvoltage
	localparam int F_UVP      = 1;	// Cell undervoltage
	localparam int F_OCD      = 2;	// Discharge overcurrent
	localparam int F_OCC      = 3;	// Charge overcurrent
	localparam int F_SHT      = 4;	// Load short circuit

	// ----------------------------------------------------------------
	// Timing: the delay timers run on a 1 us tick from a divider
	// ----------------------------------------------------------------
	localparam int CLK_MHZ     = 250;
	localparam int TICK_US     = 1;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int CNT_W       = 23;	// Holds 4.5 s of 1 us ticks

	// Manufacture-time delay options in microseconds, four each
	localparam int unsigned OVP_OPT_US [4] = '{250000, 1000000, 1250000, 4500000};
	localparam int unsigned UVP_OPT_US [4] = '{20000, 96000, 125000, 144000};
	localparam int unsigned OCD_OPT_US [4] = '{8000, 16000, 20000, 48000};
	localparam int unsigned OCC_OPT_US [4] = '{4000, 6000, 8000, 16000};
	localparam int unsigned SHT_DLY_US     = 250;	// Fixed, not selectable
	localparam int unsigned REC_DLY_US     = 1000;	// Recovery hold time

	// Factory selections
	localparam int OVP_SEL = 0;
	localparam int UVP_SEL = 0;
	localparam int OCD_SEL = 0;
	localparam int OCC_SEL = 0;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_CONTROL   = 8'h04;
	localparam logic [7:0] REG_CONFIG    = 8'h08;
	localparam logic [1:0] CONTROL_RESET = 2'h0;
	localparam int         CTL_FORCE_CHG = 0;
	localparam int         CTL_FORCE_DSG = 1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_DECERR   = 2'h3;

	// ----------------------------------------------------------------
	// AXI4-Lite carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} cpft_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cpft_axil_rsp_t;

endpackage

// file: testbench/cpft_fet_pair.sv
// Behavioural model of the external charge and discharge power FETs
`timescale 1ns/1ps
module cpft_fet_pair (
	input  wire logic chg_gate,
	input  wire logic dsg_gate,
	output logic      chg_on,
	output logic      dsg_on
);
	// ----------------------------------------------------------------
	// Gate to channel
	// ----------------------------------------------------------------
	// Logic-level NMOS: only a clean high conducts, so an unknown gate reads as off
	assign chg_on = (chg_gate === 1'b1);
	assign dsg_on = (dsg_gate === 1'b1);
endmodule

// file: testbench/tb_cell_protect_fault_timer.sv
// Self-checking bench for the cell protection fault timer
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_cell_protect_fault_timer;
	// ----------------------------------------------------------------
	// Shortened delays so every trip takes 3 to 16 ticks, one tick per cycle
	// ----------------------------------------------------------------
	localparam int CELL_OVERVOLTAGE_FAULT = 12;
	localparam int CELL_UNDERVOLTAGE_FAULT = 14;
	localparam int DISCHARGE_OVERCURRENT_FAULT = 16;
	localparam int OCC = 10;
	localparam int SHT = 3;
	localparam int REC = 5;
	logic                     clk;
	logic                     rst_n;
	logic                     above_min;
	logic                     start_lvl;
	logic                     inhibit;
	logic [4:0]               flt;
	cpft_pkg::cpft_axil_req_t req;
	cpft_pkg::cpft_axil_rsp_t rsp;
	logic                     chg_g;
	logic                     dsg_g;
	logic                     chg_on;
	logic                     dsg_on;
	logic [1:0]               gates;
	logic [31:0]              rd;
	logic [1:0]               rs;
	int                       err_total = 0;
	int                       total_checks = 0;
	int                       cyc = 0;

	assign gates = {dsg_g, chg_g};

	cpft_fault_timer #(.TICK_CYCLES(1), .OVP_DLY_TICKS(CELL_OVERVOLTAGE_FAULT), .UVP_DLY_TICKS(CELL_UNDERVOLTAGE_FAULT), .OCD_DLY_TICKS(DISCHARGE_OVERCURRENT_FAULT),
		.OCC_DLY_TICKS(OCC), .SHT_DLY_TICKS(SHT), .REC_DLY_TICKS(REC)) dut (
		.clk(clk), .rst_n(rst_n), .cell_overvoltage_fault(flt[cpft_pkg::F_OVP]),
		.cell_undervoltage_fault(flt[cpft_pkg::F_UVP]), .discharge_overcurrent_fault(flt[cpft_pkg::F_OCD]),
		.charge_overcurrent_fault(flt[cpft_pkg::F_OCC]), .load_short_fault(flt[cpft_pkg::F_SHT]),
		.charger_above_min(above_min), .zero_volt_charge_start_level(start_lvl),
		.zero_volt_charge_inhibit_level(inhibit), .axil_req(req), .axil_rsp(rsp),
		.charge_gate_out(chg_g), .discharge_gate_out(dsg_g));

	cpft_fet_pair fets (.chg_gate(chg_g), .dsg_gate(dsg_g), .chg_on(chg_on), .dsg_on(dsg_on));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic end_test(input string n);
		$display("test %s finished", n);
	endtask

	// Write with address and data offered together; trailing edge keeps strobes single per step
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		req.awaddr  <= a;
		req.wdata   <= d;
		req.wstrb   <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		do @(posedge clk); while (rsp.awready !== 1'b1 || rsp.wready !== 1'b1);
		req.awvalid <= 1'b0;
		req.wvalid  <= 1'b0;
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready  <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready  <= 1'b0;
		@(posedge clk);
	endtask

	// Hold a fault through its delay, then clear it and watch the recovery hold
	task automatic trip_rec(input int f, input int dly, input int g);
		int n = 0;
		flt[f] <= 1'b1;
		repeat (dly - 1) @(posedge clk);
		`CHK(gates[g], 1'b1)
		while (gates[g] !== 1'b0 && n < 6) begin
			@(posedge clk);
			n++;
		end
		`CHK(gates[g], 1'b0)
		flt[f] <= 1'b0;
		repeat (REC - 1) @(posedge clk);
		`CHK(gates[g], 1'b0)
		n = 0;
		while (gates[g] !== 1'b1 && n < 6) begin
			@(posedge clk);
			n++;
		end
		`CHK(gates[g], 1'b1)
		end_test("trip");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		flt = '0;
		above_min = 1'b0;
		start_lvl = 1'b0;
		inhibit = 1'b0;
		req = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axr(cpft_pkg::REG_STATUS, rd, rs);
		`CHK(rd[11:0], 12'hC00)
		`CHK({dsg_on, chg_on}, 2'b11)
		end_test("idle");
		// Delay selections are read-only and writes leave them untouched
		axr(cpft_pkg::REG_CONFIG, rd, rs);
		`CHK(rd, 32'h0000_0001)
		axw(cpft_pkg::REG_CONFIG, 32'hFFFF_FFFE, rs);
		`CHK(rs, cpft_pkg::RESP_OKAY)
		axr(cpft_pkg::REG_CONFIG, rd, rs);
		`CHK(rd, 32'h0000_0001)
		axw(8'hFC, 32'h0000_0003, rs);
		`CHK(rs, cpft_pkg::RESP_DECERR)
		axr(8'h40, rd, rs);
		`CHK({rs, rd}, {cpft_pkg::RESP_DECERR, 32'h0000_0000})
		axw(cpft_pkg::REG_CONTROL, 32'h0000_0003, rs);
		repeat (3) @(posedge clk);
		`CHK(gates, 2'b00)
		axw(cpft_pkg::REG_CONTROL, 32'h0000_0000, rs);
		repeat (3) @(posedge clk);
		`CHK(gates, 2'b11)
		end_test("registers");
		trip_rec(cpft_pkg::F_OVP, CELL_OVERVOLTAGE_FAULT, 0);
		trip_rec(cpft_pkg::F_UVP, CELL_UNDERVOLTAGE_FAULT, 1);
		trip_rec(cpft_pkg::F_OCD, DISCHARGE_OVERCURRENT_FAULT, 1);
		trip_rec(cpft_pkg::F_SHT, SHT, 1);
		trip_rec(cpft_pkg::F_OCC, OCC, 0);
		// A one-cycle gap must restart the count, so no early trip
		flt[cpft_pkg::F_OCD] <= 1'b1;
		repeat (DISCHARGE_OVERCURRENT_FAULT - 3) @(posedge clk);
		flt[cpft_pkg::F_OCD] <= 1'b0;
		@(posedge clk);
		trip_rec(cpft_pkg::F_OCD, DISCHARGE_OVERCURRENT_FAULT, 1);
		// Charge overcurrent during over-discharge leaves the charge gate alone
		flt[cpft_pkg::F_UVP] <= 1'b1;
		repeat (CELL_UNDERVOLTAGE_FAULT + 8) @(posedge clk);
		`CHK(gates, 2'b01)
		flt[cpft_pkg::F_OCC] <= 1'b1;
		repeat (OCC + 8) @(posedge clk);
		`CHK(gates, 2'b01)
		flt <= '0;
		repeat (REC + 8) @(posedge clk);
		`CHK(gates, 2'b11)
		end_test("uvp_occ");
		// Depleted cell: charge gate only with charger above minimum and at start level
		inhibit <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			{above_min, start_lvl} <= i[1:0];
			repeat (6) @(posedge clk);
			`CHK(chg_g, (i == 3))
		end
		inhibit <= 1'b0;
		{above_min, start_lvl} <= 2'b00;
		repeat (6) @(posedge clk);
		`CHK(gates, 2'b11)
		end_test("zero_volt");
		tally_and_finish();
	end
endmodule
